//--- design/uart_spi_pkg.sv
// constants shared by the serial-port uart design
package uart_spi_pkg;
	localparam int FRAME_BITS = 16;
	localparam int CMD_HI = 15;
	localparam int CMD_LO = 14;
	localparam logic [1:0] CMD_WRITE_CFG = 2'h3;
	localparam logic [1:0] CMD_READ_CFG = 2'h1;
	localparam logic [1:0] CMD_WRITE_DATA = 2'h2;
	localparam logic [1:0] CMD_READ_DATA = 2'h0;
	// write configuration word fields
	localparam int CFG_FEN_N = 13;
	localparam int CFG_TM = 11;
	localparam int CFG_RM = 10;
	localparam int CFG_PM = 9;
	localparam int CFG_RAM = 8;
	localparam int CFG_IR = 7;
	localparam int CFG_PE = 5;
	localparam int CFG_WLEN = 4;
	localparam int CFG_BAUD_HI = 3;
	// write data word fields
	localparam int WD_RTS = 9;
	localparam int WD_EXTRA = 8;
	// data reply word fields
	localparam int RD_FE = 10;
	localparam int RD_CTS = 9;
	// reset values and parameter defaults
	localparam logic [3:0] BAUD_SEL_RST = 4'h0;
	localparam logic FEN_N_RST = 1'b0;
	localparam logic [23:0] BAUD_UNIT_CYCLES_DEF = 24'h000010;
	localparam int FIFO_DEPTH_DEF = 8;
	localparam int FIFO_WIDTH_DEF = 9;
endpackage : uart_spi_pkg

//--- design/uart_spi_top.sv
// serial-port uart core with receive fifo
`timescale 1ns/1ps

module rx_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 8
) (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0] count_reg;
	wire push = in_valid_in && in_ready_out;
	wire pop = out_valid_out && out_ready_in;
	wire [AW-1:0] last_ptr = AW'(DEPTH - 1);

	assign in_ready_out = (count_reg != (AW+1)'(DEPTH));
	assign out_valid_out = (count_reg != '0);
	assign out_data_out = mem[rd_ptr_reg];

	always_ff @(posedge clk_in) begin
		if (push)
			mem[wr_ptr_reg] <= in_data_in;
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (push)
				wr_ptr_reg <= (wr_ptr_reg == last_ptr) ? '0 : wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= (rd_ptr_reg == last_ptr) ? '0 : rd_ptr_reg + 1'b1;
			if (push && !pop)
				count_reg <= count_reg + 1'b1;
			else if (pop && !push)
				count_reg <= count_reg - 1'b1;
		end
	end
endmodule : rx_fifo

module uart_spi_top
	import uart_spi_pkg::*;
#(
	parameter logic [23:0] BAUD_UNIT_CYCLES = BAUD_UNIT_CYCLES_DEF,
	parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
	// system
	input wire logic clk_in,
	input wire logic sys_rst_in,
	// serial port from the host
	input wire logic sclk_in,
	input wire logic cs_n_in,
	input wire logic mosi_in,
	output logic miso_out,
	output logic miso_oe_out,
	// uart line and handshake
	input wire logic rx_in,
	output logic tx_out,
	input wire logic cts_n_in,
	output logic rts_n_out,
	// open-drain interrupt
	output logic irq_n_out,
	output logic irq_oe_out
);
	typedef enum logic [4:0] {
		TX_IDLE = 5'b00001, TX_START = 5'b00010, TX_DATA = 5'b00100,
		TX_EXTRA = 5'b01000, TX_STOP = 5'b10000
	} tx_state_t;
	typedef enum logic [4:0] {
		RX_IDLE = 5'b00001, RX_START = 5'b00010, RX_DATA = 5'b00100,
		RX_EXTRA = 5'b01000, RX_STOP = 5'b10000
	} rx_state_t;

	// link domain: runs on sclk, cleared while select is high
	logic [4:0] bit_cnt_reg;
	logic [FRAME_BITS-1:0] in_shift_reg;
	logic [FRAME_BITS-1:0] frame_word_reg;
	logic frame_ok_reg;
	logic [1:0] cmd_reg;
	logic out_bit_reg;
	logic started_reg;
	logic [FRAME_BITS-1:0] cfg_reply_reg;
	logic [FRAME_BITS-1:0] data_reply_reg;
	wire [3:0] out_index = 4'(FRAME_BITS - 1) - bit_cnt_reg[3:0];
	wire use_cfg_reply = (cmd_reg == CMD_READ_CFG);

	always_ff @(posedge sclk_in or posedge cs_n_in) begin
		if (cs_n_in) begin
			bit_cnt_reg <= '0;
			in_shift_reg <= '0;
			frame_word_reg <= '0;
			frame_ok_reg <= 1'b0;
			cmd_reg <= CMD_READ_DATA;
		end else if (!frame_ok_reg) begin
			bit_cnt_reg <= bit_cnt_reg + 1'b1;
			in_shift_reg <= {in_shift_reg[FRAME_BITS-2:0], mosi_in};
			if (bit_cnt_reg == 5'h01)
				cmd_reg <= {in_shift_reg[0], mosi_in};
			if (bit_cnt_reg == 5'(FRAME_BITS - 1)) begin
				frame_word_reg <= {in_shift_reg[FRAME_BITS-2:0], mosi_in};
				frame_ok_reg <= 1'b1;
			end
		end
	end

	// replies are frozen by the system side while select is low
	always_ff @(negedge sclk_in or posedge cs_n_in) begin
		if (cs_n_in) begin
			out_bit_reg <= 1'b0;
			started_reg <= 1'b0;
		end else begin
			started_reg <= 1'b1;
			out_bit_reg <= use_cfg_reply ? cfg_reply_reg[out_index]
				: data_reply_reg[out_index];
		end
	end

	// bit 15 must appear at the select fall, before any sclk edge
	assign miso_out = started_reg ? out_bit_reg : data_reply_reg[FRAME_BITS-1];
	assign miso_oe_out = !cs_n_in;

	// system domain synchronisers
	logic cs_s1_reg, cs_s2_reg, ok_s1_reg, ok_s2_reg, ok_s3_reg;
	logic rx_s1_reg, rx_s2_reg, cts_s1_reg, cts_s2_reg;
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			cs_s1_reg <= 1'b1;
			cs_s2_reg <= 1'b1;
			ok_s1_reg <= 1'b0;
			ok_s2_reg <= 1'b0;
			ok_s3_reg <= 1'b0;
			rx_s1_reg <= 1'b1;
			rx_s2_reg <= 1'b1;
			cts_s1_reg <= 1'b1;
			cts_s2_reg <= 1'b1;
		end else begin
			cs_s1_reg <= cs_n_in;
			cs_s2_reg <= cs_s1_reg;
			ok_s1_reg <= frame_ok_reg;
			ok_s2_reg <= ok_s1_reg;
			ok_s3_reg <= ok_s2_reg;
			rx_s1_reg <= rx_in;
			rx_s2_reg <= rx_s1_reg;
			cts_s1_reg <= cts_n_in;
			cts_s2_reg <= cts_s1_reg;
		end
	end
	wire frame_done = ok_s2_reg && !ok_s3_reg;
	wire [1:0] frame_cmd = frame_word_reg[CMD_HI:CMD_LO];

	// configuration and status
	logic [3:0] baud_sel_reg;
	logic fifo_enable_n_reg, infrared_mode_reg, extra_bit_enable_reg, word_len_reg;
	logic extra_bit_irq_mask_reg, receive_irq_mask_reg, activity_irq_mask_reg;
	logic tx_empty_irq_mask_reg, rts_n_reg, framing_flag_reg;
	logic tx_buf_full_reg;
	logic [8:0] tx_buf_reg;
	logic irq_n_reg, irq_oe_reg;

	wire fifo_out_valid;
	wire [8:0] fifo_out_data;
	wire fifo_in_ready;
	wire tx_take;
	logic rx_good, rx_bad;
	wire receive_flag = fifo_out_valid;
	wire tx_empty_flag = !tx_buf_full_reg;
	wire receive_extra_bit = fifo_out_valid && fifo_out_data[8];
	wire cts_bit = !cts_s2_reg;
	wire wr_cfg = frame_done && (frame_cmd == CMD_WRITE_CFG);
	wire wr_data = frame_done && (frame_cmd == CMD_WRITE_DATA);
	wire data_frame = frame_done && !frame_cmd[0];
	wire fifo_pop = data_frame && fifo_out_valid;
	wire [7:0] tx_word_masked = word_len_reg ? {1'b0, frame_word_reg[6:0]}
		: frame_word_reg[7:0];
	wire irq_active = (receive_irq_mask_reg && receive_flag)
		|| (extra_bit_irq_mask_reg && receive_extra_bit)
		|| (activity_irq_mask_reg && framing_flag_reg)
		|| (tx_empty_irq_mask_reg && tx_empty_flag);
	wire [FRAME_BITS-1:0] cfg_reply_next = {receive_flag, tx_empty_flag, fifo_enable_n_reg,
		1'b0, tx_empty_irq_mask_reg, receive_irq_mask_reg, extra_bit_irq_mask_reg,
		activity_irq_mask_reg, infrared_mode_reg, 1'b0, extra_bit_enable_reg,
		word_len_reg, baud_sel_reg};
	wire [FRAME_BITS-1:0] data_reply_next = {receive_flag, tx_empty_flag, 3'h0,
		framing_flag_reg, cts_bit, receive_extra_bit,
		fifo_out_valid ? fifo_out_data[7:0] : 8'h00};

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			baud_sel_reg <= BAUD_SEL_RST;
			fifo_enable_n_reg <= FEN_N_RST;
			infrared_mode_reg <= 1'b0;
			extra_bit_enable_reg <= 1'b0;
			word_len_reg <= 1'b0;
			extra_bit_irq_mask_reg <= 1'b0;
			receive_irq_mask_reg <= 1'b0;
			activity_irq_mask_reg <= 1'b0;
			tx_empty_irq_mask_reg <= 1'b0;
		end else if (wr_cfg) begin
			baud_sel_reg <= frame_word_reg[CFG_BAUD_HI:0];
			fifo_enable_n_reg <= frame_word_reg[CFG_FEN_N];
			infrared_mode_reg <= frame_word_reg[CFG_IR];
			extra_bit_enable_reg <= frame_word_reg[CFG_PE];
			word_len_reg <= frame_word_reg[CFG_WLEN];
			extra_bit_irq_mask_reg <= frame_word_reg[CFG_PM];
			receive_irq_mask_reg <= frame_word_reg[CFG_RM];
			activity_irq_mask_reg <= frame_word_reg[CFG_RAM];
			tx_empty_irq_mask_reg <= frame_word_reg[CFG_TM];
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			rts_n_reg <= 1'b1;
			tx_buf_full_reg <= 1'b0;
			tx_buf_reg <= '0;
			framing_flag_reg <= 1'b0;
			irq_n_reg <= 1'b1;
			irq_oe_reg <= 1'b0;
			cfg_reply_reg <= '0;
			data_reply_reg <= '0;
		end else begin
			if (wr_data) begin
				rts_n_reg <= !frame_word_reg[WD_RTS];
			end
			if (wr_data && !tx_buf_full_reg) begin
				tx_buf_reg <= {frame_word_reg[WD_EXTRA], tx_word_masked};
				tx_buf_full_reg <= 1'b1;
			end else if (tx_take) begin
				tx_buf_full_reg <= 1'b0;
			end
			// a framing error in the clearing cycle still wins
			if (rx_bad)
				framing_flag_reg <= 1'b1;
			else if (rx_good || wr_cfg)
				framing_flag_reg <= 1'b0;
			irq_n_reg <= !irq_active;
			irq_oe_reg <= irq_active;
			if (cs_s2_reg) begin
				cfg_reply_reg <= cfg_reply_next;
				data_reply_reg <= data_reply_next;
			end
		end
	end

	// baud timing shared by both directions
	wire [23:0] bit_period = BAUD_UNIT_CYCLES << baud_sel_reg;
	wire [23:0] half_period = bit_period >> 1;
	wire [23:0] ir_width = 24'((bit_period * 24'h000003) >> 4);
	wire [3:0] data_bits = word_len_reg ? 4'h7 : 4'h8;

	// transmitter
	tx_state_t tx_state_reg;
	logic [23:0] tx_cnt_reg;
	logic [3:0] tx_bits_reg;
	logic [8:0] tx_shift_reg;
	logic tx_line_reg;
	wire tx_tick = (tx_cnt_reg == bit_period - 24'h000001);
	assign tx_take = (tx_state_reg == TX_IDLE) && tx_buf_full_reg;
	wire tx_level = (tx_state_reg == TX_START) ? 1'b0
		: (tx_state_reg == TX_DATA) ? tx_shift_reg[0]
		: (tx_state_reg == TX_EXTRA) ? tx_shift_reg[8] : 1'b1;

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			tx_state_reg <= TX_IDLE;
			tx_cnt_reg <= '0;
			tx_bits_reg <= '0;
			tx_shift_reg <= '0;
			tx_line_reg <= 1'b1;
		end else begin
			tx_cnt_reg <= (tx_state_reg == TX_IDLE || tx_tick) ? '0 : tx_cnt_reg + 1'b1;
			// infrared sends a short high pulse for each zero bit
			tx_line_reg <= infrared_mode_reg ? (!tx_level && tx_cnt_reg < ir_width)
				: tx_level;
			unique case (tx_state_reg)
				TX_IDLE: begin
					if (tx_take) begin
						tx_shift_reg <= tx_buf_reg;
						tx_bits_reg <= '0;
						tx_state_reg <= TX_START;
					end
				end
				TX_START: begin
					if (tx_tick)
						tx_state_reg <= TX_DATA;
				end
				TX_DATA: begin
					if (tx_tick) begin
						tx_shift_reg <= {tx_shift_reg[8], 1'b0, tx_shift_reg[7:1]};
						tx_bits_reg <= tx_bits_reg + 1'b1;
						if (tx_bits_reg == data_bits - 4'h1)
							tx_state_reg <= extra_bit_enable_reg ? TX_EXTRA : TX_STOP;
					end
				end
				TX_EXTRA: begin
					if (tx_tick)
						tx_state_reg <= TX_STOP;
				end
				TX_STOP: begin
					if (tx_tick)
						tx_state_reg <= TX_IDLE;
				end
			endcase
		end
	end

	// receiver: samples mid-bit; infrared counts any pulse since the last sample
	rx_state_t rx_state_reg;
	logic [23:0] rx_cnt_reg;
	logic [3:0] rx_bits_reg;
	logic [7:0] rx_shift_reg;
	logic rx_extra_reg, rx_pulse_seen_reg, rx_pending_reg;
	logic [8:0] rx_hold_reg;
	wire rx_zero = infrared_mode_reg ? rx_s2_reg : !rx_s2_reg;
	wire rx_sample = (rx_cnt_reg == ((rx_state_reg == RX_START) ? half_period
		: bit_period - 24'h000001));
	wire rx_bit_zero = rx_zero || (infrared_mode_reg && rx_pulse_seen_reg);
	wire [7:0] rx_data_aligned = word_len_reg ? {1'b0, rx_shift_reg[7:1]}
		: rx_shift_reg;
	wire push_allowed = fifo_in_ready && (!fifo_enable_n_reg || !fifo_out_valid);

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			rx_state_reg <= RX_IDLE;
			rx_cnt_reg <= '0;
			rx_bits_reg <= '0;
			rx_shift_reg <= '0;
			rx_extra_reg <= 1'b0;
			rx_pulse_seen_reg <= 1'b0;
			rx_pending_reg <= 1'b0;
			rx_hold_reg <= '0;
			rx_good <= 1'b0;
			rx_bad <= 1'b0;
		end else begin
			rx_good <= 1'b0;
			rx_bad <= 1'b0;
			rx_cnt_reg <= (rx_state_reg == RX_IDLE || rx_sample) ? '0 : rx_cnt_reg + 1'b1;
			rx_pulse_seen_reg <= (rx_sample || rx_state_reg == RX_IDLE) ? 1'b0
				: (rx_pulse_seen_reg || rx_zero);
			if (rx_pending_reg && push_allowed)
				rx_pending_reg <= 1'b0;
			unique case (rx_state_reg)
				RX_IDLE: begin
					if (rx_zero)
						rx_state_reg <= RX_START;
				end
				RX_START: begin
					if (rx_sample) begin
						rx_bits_reg <= '0;
						rx_extra_reg <= 1'b0;
						rx_state_reg <= rx_bit_zero ? RX_DATA : RX_IDLE;
					end
				end
				RX_DATA: begin
					if (rx_sample) begin
						rx_shift_reg <= {!rx_bit_zero, rx_shift_reg[7:1]};
						rx_bits_reg <= rx_bits_reg + 1'b1;
						if (rx_bits_reg == data_bits - 4'h1)
							rx_state_reg <= extra_bit_enable_reg ? RX_EXTRA : RX_STOP;
					end
				end
				RX_EXTRA: begin
					if (rx_sample) begin
						rx_extra_reg <= !rx_bit_zero;
						rx_state_reg <= RX_STOP;
					end
				end
				RX_STOP: begin
					if (rx_sample) begin
						rx_state_reg <= RX_IDLE;
						if (rx_bit_zero) begin
							rx_bad <= 1'b1;
						end else begin
							rx_good <= 1'b1;
							// a character arriving while one still waits and cannot be pushed is lost
							if (!rx_pending_reg || push_allowed) begin
								rx_pending_reg <= 1'b1;
								rx_hold_reg <= {rx_extra_reg && extra_bit_enable_reg,
									rx_data_aligned};
							end
						end
					end
				end
			endcase
		end
	end

	rx_fifo #(
		.WIDTH(FIFO_WIDTH_DEF),
		.DEPTH(FIFO_DEPTH)
	) u_rx_fifo (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.in_valid_in(rx_pending_reg && push_allowed),
		.in_ready_out(fifo_in_ready),
		.in_data_in(rx_hold_reg),
		.out_valid_out(fifo_out_valid),
		.out_ready_in(fifo_pop),
		.out_data_out(fifo_out_data)
	);

	assign tx_out = tx_line_reg;
	assign rts_n_out = rts_n_reg;
	assign irq_n_out = irq_n_reg;
	assign irq_oe_out = irq_oe_reg;
endmodule : uart_spi_top

//--- sim/host_spi_model.sv
// behavioural host that runs 16-bit mode-0 frames on the serial port
`timescale 1ns/1ps
module host_spi_model (
	// serial port
	output logic sclk_out,
	output logic cs_n_out,
	output logic mosi_out,
	input wire logic miso_in
);
	// a select pulse at start clears the link side, which has no other reset
	initial begin
		sclk_out = 1'b0;
		cs_n_out = 1'b0;
		mosi_out = 1'b0;
		#1 cs_n_out = 1'b1;
	end
	// a short count gives an aborted frame; the clock only runs inside frames
	task automatic xfer(input logic [15:0] word, input int nbits, output logic [15:0] reply);
		reply = 16'h0000;
		cs_n_out = 1'b0;
		#24;
		for (int i = 15; i > 15 - nbits; i--) begin
			mosi_out = word[i];
			#6 sclk_out = 1'b1;
			reply[i] = miso_in;
			#6 sclk_out = 1'b0;
		end
		// hold select long enough for the word to cross into the system clock
		#40 cs_n_out = 1'b1;
		mosi_out = ~mosi_out;
		#30;
	endtask : xfer
endmodule : host_spi_model

//--- sim/uart_spi_top_assertions.sv
// pin-level assertion checker for the serial-port uart
`timescale 1ns/1ps
module uart_spi_top_checker (
	// watched pins
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic cs_n_in,
	input wire logic miso_oe_out,
	input wire logic cts_n_in,
	input wire logic tx_out,
	input wire logic rts_n_out,
	input wire logic irq_n_out,
	input wire logic irq_oe_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);
	a_oe_follows_cs: assert property (miso_oe_out == !cs_n_in)
		else $error("miso enable does not follow select");
	a_oe_release: assert property ($rose(cs_n_in) |-> !miso_oe_out)
		else $error("miso still driven after select rose");
	a_irq_od_pair: assert property (irq_n_out != irq_oe_out)
		else $error("interrupt level and enable disagree");
	a_rel_rts_high: assert property ($fell(sys_rst_in) |-> rts_n_out [*8])
		else $error("request-to-send active after reset");
	a_rel_tx_idle: assert property ($fell(sys_rst_in) |-> tx_out [*8])
		else $error("transmit line not idle high after reset");
	a_rel_irq_off: assert property ($fell(sys_rst_in) |-> irq_n_out [*8])
		else $error("interrupt active with masks cleared");
	a_rts_idle_stable: assert property (cs_n_in [*4] |-> $stable(rts_n_out))
		else $error("request-to-send moved with no frame");
	a_cts_no_rts: assert property (cs_n_in && $changed(cts_n_in) |=> $stable(rts_n_out) [*2])
		else $error("clear-to-send pin disturbed request-to-send");
	c_frame_end: cover property ($rose(cs_n_in));
	c_irq_on: cover property ($fell(irq_n_out));
	c_rts_on: cover property ($fell(rts_n_out));
endmodule : uart_spi_top_checker

bind uart_spi_top uart_spi_top_checker i_chk (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
	.cs_n_in(cs_n_in), .miso_oe_out(miso_oe_out), .cts_n_in(cts_n_in), .tx_out(tx_out),
	.rts_n_out(rts_n_out), .irq_n_out(irq_n_out), .irq_oe_out(irq_oe_out));

//--- sim/uart_spi_top_tb_top.sv
// self-checking bench for the serial-port uart, tx looped back to rx
`timescale 1ns/1ps
module uart_spi_top_tb_top
	import uart_spi_pkg::*;
;
	typedef struct packed {
		logic [15:0] cfg;
		logic [15:0] exp;
		logic irq;
		logic tx;
	} row_t;
	localparam int DEPTH = 8;
	logic clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic cts_n_in = 1'b1;
	logic sclk, cs_n, mosi, miso, miso_oe, tx, rts_n, irq_n, irq_oe;
	wire miso_line = miso_oe ? miso : ~miso;
	// the bench takes over the receive line to fill the fifo without data frames
	logic rx_drv = 1'b1;
	logic rx_own = 1'b0;
	wire rx_line = rx_own ? rx_drv : tx;
	wire irq_line = !irq_oe;
	int n_mismatch = 0;
	int n_tests = 0;
	int cycles = 0;
	logic [15:0] r;
	row_t rows [5] = '{'{16'hc03f, 16'h403f, 1'b1, 1'b1}, '{16'hc800, 16'h4800, 1'b0, 1'b1},
		'{16'hc700, 16'h4700, 1'b1, 1'b1}, '{16'hc000, 16'h4000, 1'b1, 1'b1},
		'{16'he085, 16'h6085, 1'b1, 1'b0}};

	always #2.5 clk_in = ~clk_in;

	uart_spi_top #(.BAUD_UNIT_CYCLES(24'h000004), .FIFO_DEPTH(DEPTH)) i_dut (
		.clk_in(clk_in), .sys_rst_in(sys_rst_in), .sclk_in(sclk), .cs_n_in(cs_n),
		.mosi_in(mosi), .miso_out(miso), .miso_oe_out(miso_oe), .rx_in(rx_line), .tx_out(tx),
		.cts_n_in(cts_n_in), .rts_n_out(rts_n), .irq_n_out(irq_n), .irq_oe_out(irq_oe));
	host_spi_model i_host (.sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi), .miso_in(miso_line));

	task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", what, e, g);
		end
	endtask : chk

	task automatic close_out;
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : close_out

	task automatic frame(input logic [15:0] w);
		i_host.xfer(w, 16, r);
	endtask : frame

	task automatic do_reset;
		@(negedge clk_in);
		sys_rst_in = 1'b1;
		repeat (12) @(negedge clk_in);
		sys_rst_in = 1'b0;
		repeat (8) @(negedge clk_in);
	endtask : do_reset

	// one character at baud select 0 (four clocks a bit), then two idle bits
	task automatic send_rx(input logic [7:0] d, input logic stop_bit);
		logic [11:0] f;
		f = {2'b11, stop_bit, d, 1'b0};
		@(negedge clk_in);
		for (int b = 0; b < 12; b++) begin
			rx_drv = f[b];
			repeat (4) @(negedge clk_in);
		end
	endtask : send_rx

	task automatic loop_case(input logic [15:0] cfg, input logic [15:0] wd, input logic [15:0] e);
		int k;
		frame(cfg);
		frame(wd);
		k = 0;
		while (irq_line !== 1'b0 && k < 400) begin
			@(negedge clk_in);
			k++;
		end
		chk("irq on", 16'h0000, {15'h0000, irq_line});
		frame({CMD_READ_DATA, 14'h0000});
		chk("rx word", e, r);
		chk("irq off", 16'h0001, {15'h0000, irq_line});
	endtask : loop_case

	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			close_out();
		end
	end

	initial begin
		do_reset();
		foreach (rows[i]) begin
			frame(rows[i].cfg);
			frame({CMD_READ_CFG, 14'h0000});
			chk("cfg readback", rows[i].exp, r);
			chk("irq pin", {15'h0000, rows[i].irq}, {15'h0000, irq_line});
			chk("tx idle", {15'h0000, rows[i].tx}, {15'h0000, tx});
		end
		$display("test config rows done");
		do_reset();
		frame({CMD_READ_CFG, 14'h0000});
		chk("reset cfg", 16'h4000, r);
		chk("reset rts", 16'h0001, {15'h0000, rts_n});
		i_host.xfer(16'hc00f, 15, r);
		frame({CMD_READ_CFG, 14'h0000});
		chk("aborted cfg", 16'h4000, r);
		$display("test reset and abort done");
		for (int v = 0; v < 2; v++) begin
			@(negedge clk_in);
			cts_n_in = v[0];
			repeat (4) @(negedge clk_in);
			frame({CMD_READ_DATA, 14'h0000});
			chk("cts bit", {15'h0000, ~v[0]}, {15'h0000, r[9]});
		end
		$display("test clear-to-send done");
		loop_case(16'hc230, 16'h81ff, 16'hc17f);
		loop_case(16'hc400, 16'h81a5, 16'hc0a5);
		$display("test loopback done");
		// write data frames pop the fifo too, so the fill comes from the bench line
		frame(16'hc400);
		@(negedge clk_in);
		rx_own = 1'b1;
		for (int i = 0; i <= DEPTH; i++)
			send_rx(i[7:0], 1'b1);
		rx_own = 1'b0;
		for (int i = 0; i <= DEPTH + 1; i++) begin
			frame({CMD_READ_DATA, 14'h0000});
			if (i <= DEPTH)
				chk("fifo word", {8'hc0, i[7:0]}, r);
			else
				chk("fifo empty", 16'h0000, {15'h0000, r[15]});
		end
		$display("test fifo fill and drain done");
		frame(16'hc100);
		@(negedge clk_in);
		rx_own = 1'b1;
		send_rx(8'h00, 1'b0);
		rx_own = 1'b0;
		chk("framing irq", 16'h0000, {15'h0000, irq_line});
		frame({CMD_READ_DATA, 14'h0000});
		chk("framing flag", 16'h4400, r);
		chk("framing kept", 16'h0000, {15'h0000, irq_line});
		frame(16'hc100);
		chk("framing cleared", 16'h0001, {15'h0000, irq_line});
		$display("test framing error done");
		frame(16'h8200);
		chk("rts low", 16'h0000, {15'h0000, rts_n});
		frame(16'h8000);
		chk("rts high", 16'h0001, {15'h0000, rts_n});
		$display("test request-to-send done");
		close_out();
	end
endmodule : uart_spi_top_tb_top
